// File: urb_pkg.sv
// Shared constants and types for the serial receive buffer block.
// Assumes a single system clock and an AXI4-Lite master with 32-bit data.
package urb_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_CTRL3  = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;

  // Status register bit positions
  localparam int STAT_DONE    = 7;
  localparam int STAT_STOPERR = 4;
  localparam int STAT_LOST    = 3;
  localparam int STAT_PARERR  = 2;
  localparam int STAT_DBL     = 1;
  // Second control register bit positions
  localparam int CTRL2_IRQEN = 7;
  localparam int CTRL2_RXON  = 4;
  localparam int CTRL2_CSZ2  = 2;
  localparam int CTRL2_RX9   = 1;
  // Third control register bit positions
  localparam int CTRL3_PEN  = 5;
  localparam int CTRL3_PODD = 4;
  localparam int CTRL3_SBS  = 3;
  localparam int CTRL3_CSZ1 = 2;
  localparam int CTRL3_CSZ0 = 1;

  // Sampling figures per bit
  localparam logic [4:0] SPB_NORMAL        = 5'h10;
  localparam logic [4:0] SPB_DOUBLE        = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_SPAN         = 5'h02;
  localparam logic [2:0] CSZ_NINE          = 3'h7;

  // Reset values
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0003;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One buffered character with its flags
  typedef struct packed {
    logic       ninth;
    logic       stopErr;
    logic       overrun;
    logic       parErr;
    logic [7:0] data;
  } urb_entry_s;

  localparam int ENTRY_W = $bits(urb_entry_s);

  // Receiver states, Gray from idle to stop with parity; data to stop without parity and stop back to idle flip two bits
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } urb_state_e;

endpackage : urb_pkg

// File: urb_rx_fifo.sv
// Small first-in first-out store for received characters.
// Assumes one clock; flush empties it at once, pop and push may coincide.
`timescale 1ns/100ps
module urb_rx_fifo import urb_pkg::*; #(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  wrReady,
  input  wire logic             rdPop,
  output logic                  rdValid,
  output logic      [WIDTH-1:0] rdData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("urb_rx_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshake terms
  assign wrReady = (count_r != AW'(0) + (AW+1)'(DEPTH));
  assign rdValid = (count_r != '0);
  assign push    = wrValid && wrReady && !flush;
  assign pop     = rdPop && rdValid && !flush;
  assign rdData  = mem_r[rdPtr_r];  // Storage is flops, so this read is combinational

  ////////////////////////////////////////////////////////////////////////////
  // Storage, no reset needed since count guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r] <= wrData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + AW'(1);
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + (AW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end

endmodule : urb_rx_fifo

// File: urb_receiver.sv
// Serial receiver with two-entry character buffer and AXI4-Lite registers.
// Assumes rxLine is synchronous to clk and one AXI4-Lite master.
// What this block does
// R1 - Software reads the ninth bit before the low data byte.
// R2 - Reading the data location pops the buffer and shows the next entry.
// R3 - Receive-done flag is one exactly while an unread character is buffered.
// R4 - Clearing receiver enable flushes the buffer and drops receive-done.
// R5 - Interrupt request follows receive-done while both enables are set.
// R6 - Handler must read the data to stop the interrupt repeating.
// R7 - Error flags travel with their character and show for the head entry.
// R8 - Writes never alter the three error flags; software writes zeros.
// R9 - Error flags never raise an interrupt.
// R10 - Stop-bit error is set when the first stop bit samples low.
// R11 - Only the first stop bit is checked, whatever the stop setting.
// R12 - Overrun records a start bit seen while buffer full and one waiting.
// R13 - Overrun clears once a frame moves into the buffer.
// R14 - Parity checked only when enabled; odd select picks the sense.
// R15 - Parity error only if checked and failed; zero when checking disabled.
// R16 - Disabling the receiver abandons the frame in progress at once.
// R17 - With the receiver off the serial pin is handed back.
// R18 - To discard data, software reads data until receive-done is zero.
// R19 - Sampling aligns to each start edge and votes every bit.
// R20 - Sixteen samples per bit, eight in double speed.
// R21 - Start samples 8-10 or 4-6 voted; high majority rejects the start.
// R22 - Each bit decided by majority of its three centre samples.
// R23 - After the first stop bit the frame moves to the buffer.
// R24 - Odd select zero means even parity, one means odd parity.
// R25 - Buffer is a two-entry queue holding character and flags together.
`timescale 1ns/100ps
module urb_receiver import urb_pkg::*; #(
  parameter int DIV_W = 12,
  parameter int DEPTH = 2
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        rxLine,
  input  wire logic        globalIrqEn,
  output logic             rxDoneIrq,
  output logic             rxPinOverride
);

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
      $error("urb_receiver divider width must be 1 to 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic             awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [7:0]       awAddr_r;
  logic [31:0]      wData_r, rdata_r, readMux;
  logic [3:0]       wStrb_r;
  logic [1:0]       bresp_r, rresp_r;
  logic             doWrite, doRead, dataPop, readHit;
  logic             irqEn_r, rxOn_r, dblSpeed_r, pen_r, podd_r, sbs_r;
  logic [2:0]       csz_r;
  logic [DIV_W-1:0] baudDiv_r, divCnt_r;
  logic             tick;
  urb_state_e       state_r;
  logic [4:0]       sampCnt_r, spb, voteFirst, voteLast;
  logic [3:0]       bitIdx_r, nBits;
  logic [1:0]       votes_r;
  logic             vote, inWindow, voteNow, bitEnd, startDet, frameDone;
  logic [8:0]       shreg_r;
  logic             parBit_r, parUse_r, lost_r, lostSet;
  urb_entry_s       pend_r, wrEntry, head, shown;
  logic             pendValid_r, fifoPush, fifoWrReady, rxDone;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel: address and data taken in either order
  assign awready = !awHeld_r && !bvalid_r;
  assign wready  = !wHeld_r && !bvalid_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Write response, unmapped offsets answer SLVERR
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awAddr_r[7:2] <= ADDR_BAUD[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control fields; status flags are not writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEn_r   <= CTRL_RESET[CTRL2_IRQEN];
      rxOn_r    <= CTRL_RESET[CTRL2_RXON];
      dblSpeed_r <= CTRL_RESET[STAT_DBL];
      pen_r     <= CTRL_RESET[CTRL3_PEN];
      podd_r    <= CTRL_RESET[CTRL3_PODD];
      sbs_r     <= CTRL_RESET[CTRL3_SBS];
      csz_r     <= 3'h0;
      baudDiv_r <= BAUD_DIV_RESET[DIV_W-1:0];
    end else if (doWrite && wStrb_r[0]) begin
      case (awAddr_r[7:2])
        ADDR_STATUS[7:2]: dblSpeed_r <= wData_r[STAT_DBL];  // R8
        ADDR_CTRL2[7:2]: begin
          irqEn_r  <= wData_r[CTRL2_IRQEN];
          rxOn_r   <= wData_r[CTRL2_RXON];
          csz_r[2] <= wData_r[CTRL2_CSZ2];
        end
        ADDR_CTRL3[7:2]: begin
          pen_r      <= wData_r[CTRL3_PEN];
          podd_r     <= wData_r[CTRL3_PODD];
          sbs_r      <= wData_r[CTRL3_SBS];  // Stored only, never checked
          csz_r[1:0] <= {wData_r[CTRL3_CSZ1], wData_r[CTRL3_CSZ0]};
        end
        ADDR_BAUD[7:2]: baudDiv_r <= wData_r[DIV_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel; a data read pops the buffer
  assign arready = !rvalid_r;
  assign doRead  = arvalid && arready;
  assign readHit = (araddr[7:2] <= ADDR_BAUD[7:2]);
  assign dataPop = doRead && (araddr[7:2] == ADDR_DATA[7:2]) && rxDone;  // R2
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Empty buffer reads as zero, never as stale or unset storage
  assign shown = rxDone ? head : '0;

  // Register readback; flags shown for the head entry only
  always_comb begin
    readMux = 32'h0000_0000;
    case (araddr[7:2])
      ADDR_STATUS[7:2]: begin
        readMux[STAT_DONE]    = rxDone;  // R3
        readMux[STAT_STOPERR] = shown.stopErr;  // R7
        readMux[STAT_LOST]    = shown.overrun;
        readMux[STAT_PARERR]  = shown.parErr;
        readMux[STAT_DBL]     = dblSpeed_r;
      end
      ADDR_CTRL2[7:2]: begin
        readMux[CTRL2_IRQEN] = irqEn_r;
        readMux[CTRL2_RXON]  = rxOn_r;
        readMux[CTRL2_CSZ2]  = csz_r[2];
        readMux[CTRL2_RX9]   = shown.ninth;
      end
      ADDR_CTRL3[7:2]: begin
        readMux[CTRL3_PEN]  = pen_r;
        readMux[CTRL3_PODD] = podd_r;
        readMux[CTRL3_SBS]  = sbs_r;
        readMux[CTRL3_CSZ1] = csz_r[1];
        readMux[CTRL3_CSZ0] = csz_r[0];
      end
      ADDR_DATA[7:2]: readMux[7:0] = shown.data;
      ADDR_BAUD[7:2]: readMux[DIV_W-1:0] = baudDiv_r;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // Read data held until the master takes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (doRead) begin
      rvalid_r <= 1'b1;
      rdata_r  <= readMux;
      rresp_r  <= readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick: one per divider period
  assign tick = rxOn_r && (divCnt_r == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= '0;
    end else if (!rxOn_r || divCnt_r == '0) begin
      divCnt_r <= baudDiv_r;
    end else begin
      divCnt_r <= divCnt_r - DIV_W'(1);
    end
  end

  // Samples per bit and centre window
  assign spb       = dblSpeed_r ? SPB_DOUBLE : SPB_NORMAL;  // R20
  assign voteFirst = dblSpeed_r ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;  // R21
  assign voteLast  = voteFirst + VOTE_SPAN;
  assign nBits     = (csz_r == CSZ_NINE) ? 4'h9 : {2'b00, csz_r[1:0]} + 4'h5;
  assign inWindow  = (sampCnt_r >= voteFirst) && (sampCnt_r <= voteLast);
  assign voteNow   = tick && (sampCnt_r == voteLast);
  assign bitEnd    = tick && (sampCnt_r == spb);
  // Two of three wins; filters short glitches on the line
  assign vote      = (votes_r[1] & votes_r[0]) | (votes_r[1] & rxLine) | (votes_r[0] & rxLine);  // R22
  assign startDet  = tick && (state_r == ST_IDLE) && !rxLine;  // R19
  assign frameDone = voteNow && (state_r == ST_STOP);  // R23

  // Centre sample history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      votes_r <= 2'h0;
    end else if (tick && inWindow) begin
      votes_r <= {votes_r[0], rxLine};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame recovery state machine, restarted on every start edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      sampCnt_r <= 5'h00;
      bitIdx_r  <= 4'h0;
      shreg_r   <= 9'h000;
      parBit_r  <= 1'b0;
      parUse_r  <= 1'b0;
    end else if (!rxOn_r) begin
      state_r   <= ST_IDLE;  // R16
      sampCnt_r <= 5'h00;
    end else if (tick) begin
      sampCnt_r <= (sampCnt_r == spb) ? 5'h01 : sampCnt_r + 5'h01;
      case (state_r)
        ST_IDLE: begin
          if (!rxLine) begin
            state_r   <= ST_START;
            sampCnt_r <= 5'h02;  // Edge sample counts as sample one
            shreg_r   <= 9'h000;
            parUse_r  <= pen_r;  // R14
          end
        end
        ST_START: begin
          if (voteNow && vote) begin
            state_r <= ST_IDLE;  // R21
          end else if (bitEnd) begin
            state_r  <= ST_DATA;
            bitIdx_r <= 4'h0;
          end
        end
        ST_DATA: begin
          if (voteNow) begin
            shreg_r[bitIdx_r] <= vote;
          end
          if (bitEnd) begin
            bitIdx_r <= bitIdx_r + 4'h1;
            if (bitIdx_r == nBits - 4'h1) begin
              state_r <= parUse_r ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (voteNow) begin
            parBit_r <= vote;
          end
          if (bitEnd) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (voteNow) begin
            state_r <= ST_IDLE;  // R11
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completed frame waits here until a buffer slot frees
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendValid_r <= 1'b0;
      pend_r      <= '0;
    end else if (!rxOn_r) begin
      pendValid_r <= 1'b0;  // R4
    end else if (frameDone) begin
      pendValid_r  <= 1'b1;
      pend_r.data  <= shreg_r[7:0];
      pend_r.ninth <= (nBits == 4'h9) && shreg_r[8];
      pend_r.stopErr <= !vote;  // R10
      pend_r.overrun <= 1'b0;
      pend_r.parErr  <= parUse_r && ((^shreg_r ^ parBit_r) != podd_r);  // R15 R24
    end else if (fifoPush) begin
      pendValid_r <= 1'b0;
    end
  end

  // Lost-frame marker; a set beats a clear in the same cycle
  assign lostSet = startDet && pendValid_r && !fifoWrReady;  // R12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_r <= 1'b0;
    end else if (!rxOn_r) begin
      lost_r <= 1'b0;
    end else begin
      lost_r <= lostSet || (lost_r && !fifoPush);  // R13
    end
  end

  // Entry written with the overrun state at transfer time
  always_comb begin
    wrEntry     = pend_r;
    wrEntry.overrun = lost_r;  // R7
  end

  assign fifoPush = pendValid_r && fifoWrReady && rxOn_r;

  // Character buffer, flushed while the receiver is off
  urb_rx_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .flush   (!rxOn_r),  // R4
    .wrValid (pendValid_r),  // R25
    .wrData  (wrEntry),
    .wrReady (fifoWrReady),
    .rdPop   (dataPop),  // R2
    .rdValid (rxDone),
    .rdData  (head)
  );

  // Only receive-done reaches the interrupt, never the error flags
  assign rxDoneIrq     = irqEn_r && globalIrqEn && rxDone;  // R5 R9
  assign rxPinOverride = rxOn_r;  // R17

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  flush_clear_a: assert property (!rxOn_r |=> !rxDone) else $error("buffer not flushed");  // R4
  rx_abandon_a: assert property (!rxOn_r |=> state_r == ST_IDLE && !pendValid_r)  // R16
    else $error("reception not abandoned");
  irq_level_a: assert property (rxDoneIrq && rxOn_r && !dataPop && !doWrite |=> rxDoneIrq || !globalIrqEn)  // R5
    else $error("interrupt dropped while flag set");
  pop_frees_a: assert property (dataPop && rxOn_r && !fifoPush && !fifoWrReady |=> rxDone && fifoWrReady)  // R2
    else $error("pop did not free slot");
  start_reject_a: assert property (voteNow && state_r == ST_START && vote && rxOn_r  // R21
    |=> state_r == ST_IDLE) else $error("noisy start kept");
  frame_flag_a: assert property (frameDone && rxOn_r |=> pendValid_r && (pend_r.stopErr != $past(vote)))  // R10
    else $error("stop-bit error flag wrong");
  parity_off_a: assert property (frameDone && rxOn_r && !parUse_r |=> !pend_r.parErr)  // R15
    else $error("parity flag without checking");
  overrun_clear_a: assert property (fifoPush |=> !lost_r) else $error("overrun not cleared");  // R13
  overrun_set_a: assert property (lostSet && rxOn_r |=> lost_r ##1 1) else $error("overrun missed");  // R12
  samp_range_a: assert property (state_r != ST_IDLE |-> sampCnt_r >= 5'h01 && sampCnt_r <= spb)  // R20
    else $error("sample count out of range");
  done_status_a: assert property (doRead && araddr[7:2] == ADDR_STATUS[7:2]  // R3
    |=> rdata_r[STAT_DONE] == $past(rxDone)) else $error("receive-done readback wrong");

  frame_in_c: cover property (fifoPush);
  overrun_c: cover property (lostSet);
  reject_c: cover property (voteNow && state_r == ST_START && vote);
  parity_err_c: cover property (fifoPush && wrEntry.parErr);

endmodule : urb_receiver

// File: urb_tx_model.sv
// Model of the remote serial transmitter on the receive line.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/100ps
module urb_tx_model (
  input  wire logic clk,
  output logic      rxLine
);
  // Line idles high between frames
  initial rxLine = 1'b1;

  // Start bit, data LSB first, optional parity, one stop bit
  task automatic sendFrame(input logic [8:0] d, input int n, input bit par, input logic pb,
                           input logic stopV, input int bitClk);
    logic [11:0] bits;
    int          nb;
    bits = 12'h000;
    for (int i = 0; i < n; i++) bits[i+1] = d[i];
    nb = n + 1;
    bits[nb] = par ? pb : stopV;
    bits[nb+1] = stopV;
    nb += par ? 2 : 1;
    for (int i = 0; i < nb; i++) begin
      rxLine <= bits[i];
      repeat (bitClk) @(posedge clk);
    end
    rxLine <= 1'b1;
    // One idle clock so a following call never drives the line twice at one edge
    @(posedge clk);
  endtask : sendFrame

  // Low pulse too short to survive the start vote
  task automatic glitch(input int n);
    rxLine <= 1'b0;
    repeat (n) @(posedge clk);
    rxLine <= 1'b1;
    @(posedge clk);
  endtask : glitch
endmodule : urb_tx_model

// File: urb_receiver_tb.sv
// Self-checking bench for the serial receive buffer block.
// Assumes the baud divider is set to zero, so one line sample per clock.
`timescale 1ns/100ps
module urb_receiver_tb import urb_pkg::*; ();
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rxLine, globalIrqEn, rxDoneIrq, rxPinOverride;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  urb_receiver #(.DIV_W(12), .DEPTH(2)) dut (
    .clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rxLine, .globalIrqEn,
    .rxDoneIrq, .rxPinOverride
  );
  urb_tx_model txModel (.clk, .rxLine);

  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic chkPin(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %b seen %b", nm, e, g);
      num_errors++;
    end
  endtask : chkPin

  // Ready is looked at on the falling edge, so the rising edge sees no race
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    {aw, w, b} = 3'h0;
    while (!(aw && w)) begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      @(posedge clk);
      if (ra && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (rw && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!b) begin
      @(negedge clk);
      b = bvalid;
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = rvalid;
      rv = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, rv & m);
  endtask : rc

  ////////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    rc(ADDR_STATUS, '1, 32'h0, "status");
    rc(ADDR_CTRL2, '1, 32'h0, "ctrl2");
    rc(ADDR_CTRL3, '1, 32'h0, "ctrl3");
    rc(ADDR_BAUD, '1, 32'(BAUD_DIV_RESET), "baud");
    rc(8'h14, '1, 32'h0, "unmapped");
    chk("rresp", 32'(RESP_SLVERR), 32'(resp));
    chkPin("override", 1'b0, rxPinOverride);
    wr(8'h14, 32'h0);
    chk("bresp", 32'(RESP_SLVERR), 32'(resp));
    wr(ADDR_BAUD, 32'h0);
    chk("bresp", 32'(RESP_OKAY), 32'(resp));
    $display("test reset done");
  endtask : tReset

  // Good frame then a frame whose stop bit is low
  task automatic tBasic;
    wr(ADDR_CTRL3, 32'h06);
    wr(ADDR_CTRL2, 32'h90);
    chkPin("override", 1'b1, rxPinOverride);
    txModel.sendFrame(9'h0A5, 8, 0, 1'b0, 1'b1, 16);
    txModel.sendFrame(9'h03C, 8, 0, 1'b0, 1'b0, 16);
    rc(ADDR_STATUS, '1, 32'h80, "status");
    chkPin("irq", 1'b1, rxDoneIrq);
    globalIrqEn <= 1'b0;
    @(posedge clk);
    chkPin("irq", 1'b0, rxDoneIrq);
    globalIrqEn <= 1'b1;
    rc(ADDR_DATA, '1, 32'hA5, "data");
    wr(ADDR_STATUS, 32'h0);
    rc(ADDR_STATUS, '1, 32'h90, "status");
    rc(ADDR_DATA, '1, 32'h3C, "data");
    rc(ADDR_STATUS, 32'h80, 32'h0, "done");
    chkPin("irq", 1'b0, rxDoneIrq);
    $display("test basic done");
  endtask : tBasic

  // Both parity senses, each with a right and a wrong parity bit
  task automatic tParity;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL3, k[1] ? 32'h36 : 32'h26);
      txModel.sendFrame(9'h001, 8, 1, k[0], 1'b1, 16);
      rc(ADDR_STATUS, 32'h04, {29'h0, (1'b1 ^ k[0]) != k[1], 2'h0}, "parity");
      rc(ADDR_DATA, '1, 32'h01, "data");
    end
    $display("test parity done");
  endtask : tParity

  // Four frames unread: third waits, fourth start overruns and replaces it
  task automatic tOverrun;
    wr(ADDR_CTRL3, 32'h06);
    for (int k = 1; k < 5; k++) txModel.sendFrame(9'(k * 17), 8, 0, 1'b0, 1'b1, 16);
    rc(ADDR_STATUS, '1, 32'h80, "status");
    rc(ADDR_DATA, '1, 32'h11, "data");
    rc(ADDR_DATA, '1, 32'h22, "data");
    rc(ADDR_STATUS, 32'h08, 32'h08, "overrun");
    rc(ADDR_DATA, '1, 32'h44, "data");
    txModel.sendFrame(9'h055, 8, 0, 1'b0, 1'b1, 16);
    rc(ADDR_STATUS, 32'h08, 32'h0, "overrun");
    rc(ADDR_DATA, '1, 32'h55, "data");
    $display("test overrun done");
  endtask : tOverrun

  // Disable with one char buffered and another frame in flight
  task automatic tFlush;
    txModel.sendFrame(9'h066, 8, 0, 1'b0, 1'b1, 16);
    fork
      txModel.sendFrame(9'h0FF, 8, 0, 1'b0, 1'b1, 16);
      begin
        repeat (40) @(posedge clk);
        wr(ADDR_CTRL2, 32'h0);
        chkPin("override", 1'b0, rxPinOverride);
        wr(ADDR_CTRL2, 32'h90);
      end
    join
    rc(ADDR_STATUS, 32'h80, 32'h0, "done");
    txModel.glitch(4);
    // Long enough for a wrongly kept start to land as a whole frame
    repeat (200) @(posedge clk);
    rc(ADDR_STATUS, 32'h80, 32'h0, "done");
    $display("test flush done");
  endtask : tFlush

  // Nine-bit char at double speed with two stop bits selected
  task automatic tNine;
    wr(ADDR_STATUS, 32'h02);
    wr(ADDR_CTRL3, 32'h0E);
    wr(ADDR_CTRL2, 32'h94);
    txModel.sendFrame(9'h1AB, 9, 0, 1'b0, 1'b1, 8);
    rc(ADDR_CTRL2, 32'h02, 32'h02, "ninth");
    rc(ADDR_STATUS, '1, 32'h82, "status");
    rc(ADDR_DATA, '1, 32'hAB, "data");
    $display("test nine done");
  endtask : tNine

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // Whole run needs some 2600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 20'h00000;
    wdata = 32'h0;
    globalIrqEn = 1'b1;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tReset();
    tBasic();
    tParity();
    tOverrun();
    tFlush();
    tNine();
    give_verdict();
  end
endmodule : urb_receiver_tb
